/* rtl/clock_failure_detect_recovery.sv */
`timescale 1ns/1ns
// ==========================================
// Clock failure detection and recovery
// ==========================================
module clock_failure_detect_recovery #(
    parameter int WDT_FAIL_CYCLES = cfd_pkg::WDT_FAIL_CYCLES,
    parameter int PRI_FAIL_WDT_EDGES = cfd_pkg::PRI_FAIL_WDT_EDGES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic primary_osc_fail_detect_en,
    input wire logic wdt_osc_fail_detect_en,
    input wire logic wdt_osc_enable,
    input wire logic [2:0] clock_source_select,
    input wire logic primary_clk_seen,
    input wire logic wdt_clk_level,
    input wire logic pri_fail_ack,
    input wire logic wdt_fail_ack,
    output logic pri_fail_req_ff,
    output logic wdt_fail_req_ff,
    output logic recovery_active_ff,
    output logic [2:0] effective_source_ff,
    output logic wdt_failed_ff
);
    logic [cfd_pkg::CNT_W-1:0] wdt_gap;
    logic wdt_prev_ff;
    logic wdt_primed_ff;
    logic wdt_edge;
    logic wdt_toggle;
    logic [3:0] pri_gap_ff;
    logic pri_fail;
    logic wdt_fail;
    logic wdt_is_src;
    logic recovery_allowed;

    // ==========================================
    // Recovery state encoding
    // ==========================================
    // Watching the primary, or forced onto the watchdog oscillator
    typedef enum logic [0:0] {
        RCV_WATCH = 1'b0,
        RCV_FORCED = 1'b1
    } recover_state_t;
    recover_state_t rcv_state_ff;
    recover_state_t nxt_rcv_state;

    // ==========================================
    // Helper functions
    // ==========================================
    // Shared threshold test of both gap counters, widths matched by the caller
    function automatic logic gap_reached(
        input logic [cfd_pkg::CNT_W-1:0] gap,
        input logic [cfd_pkg::CNT_W-1:0] limit
    );
        return gap >= limit;
    endfunction : gap_reached

    // Decode of the watchdog oscillator source code
    function automatic logic names_wdt(
        input logic [2:0] code
    );
        return code == cfd_pkg::SRC_WDT;
    endfunction : names_wdt

    // ==========================================
    // Watchdog oscillator edge detection
    // ==========================================
    // First sample after reset has no history, so edges wait one clock
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            wdt_primed_ff <= 1'b0;
        else
            wdt_primed_ff <= 1'b1;
    end

    // Previous watchdog level
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            wdt_prev_ff <= 1'b0;
        else
            wdt_prev_ff <= wdt_clk_level;
    end

    // Rising edge and any level change, masked until primed to avoid a false edge
    assign wdt_edge = wdt_primed_ff && wdt_clk_level && !wdt_prev_ff;
    assign wdt_toggle = wdt_primed_ff && (wdt_clk_level != wdt_prev_ff);
    assign wdt_is_src = names_wdt(clock_source_select);

    // ==========================================
    // Watchdog oscillator failure detection
    // ==========================================
    // System clocks since the last watchdog edge
    cfd_edge_counter #(.WIDTH(cfd_pkg::CNT_W)) u_gap (
        .clock(clock),
        .rst_n(rst_n),
        .clear(wdt_edge),
        .run(wdt_osc_fail_detect_en),
        .count(wdt_gap)
    );
    // Failure when gap reaches the limit
    assign wdt_fail = wdt_osc_fail_detect_en &&
        gap_reached(wdt_gap, cfd_pkg::CNT_W'(WDT_FAIL_CYCLES - 1));

    // ==========================================
    // Primary failure: watchdog edges with no primary activity
    // ==========================================
    // Count watchdog edges while the primary stays quiet
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            pri_gap_ff <= 4'h0;
        else if (!primary_osc_fail_detect_en || primary_clk_seen || wdt_failed_ff)
            pri_gap_ff <= 4'h0;
        else if (wdt_edge && pri_gap_ff != 4'hF)
            pri_gap_ff <= pri_gap_ff + 4'h1;
    end
    // Primary failure once enough quiet watchdog edges have passed
    assign pri_fail = primary_osc_fail_detect_en && !wdt_failed_ff &&
        gap_reached(cfd_pkg::CNT_W'(pri_gap_ff), cfd_pkg::CNT_W'(PRI_FAIL_WDT_EDGES));

    // ==========================================
    // Sticky watchdog failure state
    // ==========================================
    // Set on failure, cleared once the watchdog level moves again
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            wdt_failed_ff <= 1'b0;
        else if (wdt_fail)
            wdt_failed_ff <= 1'b1;
        else if (wdt_toggle)
            wdt_failed_ff <= 1'b0;
    end

    // ==========================================
    // Primary event request
    // ==========================================
    // Pending until acknowledged; a new failure beats the acknowledge
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            pri_fail_req_ff <= 1'b0;
        else if (pri_fail)
            pri_fail_req_ff <= 1'b1;
        else if (pri_fail_ack)
            pri_fail_req_ff <= 1'b0;
    end

    // ==========================================
    // Watchdog event request
    // ==========================================
    // Pending until acknowledged; a new failure beats the acknowledge
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            wdt_fail_req_ff <= 1'b0;
        else if (wdt_fail)
            wdt_fail_req_ff <= 1'b1;
        else if (wdt_fail_ack)
            wdt_fail_req_ff <= 1'b0;
    end

    // ==========================================
    // Recovery permission
    // ==========================================
    // Recovery needs a running watchdog that is not already the source
    assign recovery_allowed = wdt_osc_enable && !wdt_is_src;

    // ==========================================
    // Recovery state machine
    // ==========================================
    // Force the watchdog source on failure, release once software is back
    always_comb
    begin
        nxt_rcv_state = rcv_state_ff;
        case (rcv_state_ff)
            RCV_WATCH:
            begin
                if (pri_fail && recovery_allowed)
                    nxt_rcv_state = RCV_FORCED;
            end
            RCV_FORCED:
            begin
                if (primary_clk_seen && !primary_osc_fail_detect_en)
                    nxt_rcv_state = RCV_WATCH;
            end
            default:
                nxt_rcv_state = RCV_WATCH;
        endcase
    end

    // Recovery state register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rcv_state_ff <= RCV_WATCH;
        else
            rcv_state_ff <= nxt_rcv_state;
    end

    // Recovery flag follows the next state so that the output is registered
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            recovery_active_ff <= 1'b0;
        else
            recovery_active_ff <= (nxt_rcv_state == RCV_FORCED);
    end

    // ==========================================
    // Effective clock source
    // ==========================================
    // Clock source handed to the clock tree; the core never halts
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            effective_source_ff <= cfd_pkg::SRC_RESET;
        else if (recovery_active_ff)
            effective_source_ff <= cfd_pkg::SRC_WDT;
        else
            effective_source_ff <= clock_source_select;
    end
endmodule : clock_failure_detect_recovery

/* rtl/cfd_pkg.sv */
// Contract
// - Primary failure raises nonmaskable event
// - Primary failure switches clock to watchdog
// - Recovery only while watchdog oscillator enabled
// - Processor keeps running on slow clock
// - No switch when watchdog already selected
// - Primary fails below about one kilohertz
// - Watchdog failure raises event, no switch
// - After watchdog failure, primary detection stops
// - Watchdog fails after 8004 cycles without edge
// - Detection re-enabled after source write (here primary detection resumes once the watchdog level toggles again)
package cfd_pkg;
    // ==========================================
    // Timing
    // ==========================================
    localparam int WDT_FAIL_CYCLES = 8004;
    // Primary threshold is 1 kHz, counted in watchdog oscillator edges
    localparam int PRI_FAIL_FREQ_HZ = 1000;
    localparam int WDT_OSC_FREQ_HZ = 10000;
    localparam int PRI_FAIL_WDT_EDGES = WDT_OSC_FREQ_HZ / PRI_FAIL_FREQ_HZ;
    localparam int CNT_W = 14;
    // ==========================================
    // Clock source selection codes
    // ==========================================
    localparam logic [2:0] SRC_IPO = 3'h0;
    localparam logic [2:0] SRC_WDT = 3'h3;
    localparam logic [2:0] SRC_RESET = 3'h0;
endpackage : cfd_pkg

/* rtl/cfd_edge_counter.sv */
`timescale 1ns/1ns
// ==========================================
// Counter of system clocks since last event
// ==========================================
module cfd_edge_counter #(
    parameter int WIDTH = 14
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic run,
    output logic [WIDTH-1:0] count
);
    // Saturating count, cleared on event or when idle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            count <= '0;
        else if (clear || !run)
            count <= '0;
        else if (count != {WIDTH{1'b1}})
            count <= count + 1'b1;
    end
endmodule : cfd_edge_counter

/* tb/cfd_props.sv */
`timescale 1ns/1ns
// ==========================================
// Port checker
// ==========================================
module cfd_props (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic primary_osc_fail_detect_en,
    input wire logic wdt_osc_fail_detect_en,
    input wire logic wdt_osc_enable,
    input wire logic [2:0] clock_source_select,
    input wire logic pri_fail_ack,
    input wire logic wdt_fail_ack,
    input wire logic pri_fail_req_ff,
    input wire logic wdt_fail_req_ff,
    input wire logic recovery_active_ff,
    input wire logic [2:0] effective_source_ff,
    input wire logic wdt_failed_ff
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Start of a forced switch
    sequence s_rise;
        $rose(recovery_active_ff);
    endsequence
    // Pending events, switch walk and enable conditions
    chk_pend_pri: assert property (pri_fail_req_ff && !pri_fail_ack |=> pri_fail_req_ff)
        else $error("primary event dropped");
    chk_pend_wdt: assert property (wdt_fail_req_ff && !wdt_fail_ack |=> wdt_fail_req_ff)
        else $error("watchdog event dropped");
    chk_switch_event: assert property (s_rise |-> pri_fail_req_ff)
        else $error("switch without event");
    chk_switch_walk: assert property (s_rise |=> effective_source_ff == cfd_pkg::SRC_WDT)
        else $error("source not moved");
    chk_recov_hold: assert property (recovery_active_ff && $past(recovery_active_ff)
        |-> effective_source_ff == cfd_pkg::SRC_WDT)
        else $error("recovery lost source");
    chk_recov_allowed: assert property (s_rise |-> $past(wdt_osc_enable)
        && $past(clock_source_select) != cfd_pkg::SRC_WDT)
        else $error("switch not allowed");
    chk_pri_enable: assert property ($rose(pri_fail_req_ff)
        |-> $past(primary_osc_fail_detect_en) && !$past(wdt_failed_ff))
        else $error("primary event without cause");
    chk_wdt_enable: assert property ($rose(wdt_fail_req_ff) |-> $past(wdt_osc_fail_detect_en))
        else $error("watchdog event while disabled");
endmodule : cfd_props
bind clock_failure_detect_recovery cfd_props chk (.*);

/* tb/osc_model.sv */
`timescale 1ns/1ns
// ==========================================
// Oscillator sources
// ==========================================
module osc_model (
    input wire logic clock,
    input wire logic pri_on,
    input wire logic wdt_on,
    output logic primary_clk_seen,
    output logic wdt_clk_level
);
    logic [1:0] div_ff = 2'h0;
    // Watchdog level toggles every two clocks, frozen when dead
    always_ff @(posedge clock)
    begin
        if (wdt_on)
            div_ff <= div_ff + 2'h1;
    end
    assign wdt_clk_level = div_ff[1];
    assign primary_clk_seen = pri_on;
endmodule : osc_model

/* tb/clock_failure_detect_recovery_bench.sv */
`timescale 1ns/1ns
// ==========================================
// Bench
// ==========================================
module clock_failure_detect_recovery_bench;
    localparam int WF = 20;
    logic clock = 1'b0, rst_n = 1'b0, pen = 1'b0, wen = 1'b0, wosc = 1'b1;
    logic pri_on = 1'b1, wdt_on = 1'b1, pack = 1'b0, wack = 1'b0;
    logic [2:0] sel = 3'h0;
    logic seen, wlev, preq, wreq, rec, dead;
    logic [2:0] src;
    int num_errors = 0;
    int total_checks = 0;
    initial forever #20 clock = ~clock;
    osc_model osc (.clock(clock), .pri_on(pri_on), .wdt_on(wdt_on),
        .primary_clk_seen(seen), .wdt_clk_level(wlev));
    clock_failure_detect_recovery #(.WDT_FAIL_CYCLES(WF), .PRI_FAIL_WDT_EDGES(3)) uut (
        .clock(clock), .rst_n(rst_n), .primary_osc_fail_detect_en(pen),
        .wdt_osc_fail_detect_en(wen), .wdt_osc_enable(wosc), .clock_source_select(sel),
        .primary_clk_seen(seen), .wdt_clk_level(wlev), .pri_fail_ack(pack),
        .wdt_fail_ack(wack), .pri_fail_req_ff(preq), .wdt_fail_req_ff(wreq),
        .recovery_active_ff(rec), .effective_source_ff(src), .wdt_failed_ff(dead));
    // Compare and wait helpers
    task chk(input string what, input logic [2:0] exp, input logic [2:0] got);
        total_checks++;
        num_errors += (got !== exp);
        if (got !== exp)
            $display("unexpected %s expected %0h seen %0h", what, exp, got);
    endtask : chk
    task cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    // Primary loss: event, switch, acknowledge, return
    task t_pri;
        pen = 1'b1;
        pri_on = 1'b0;
        for (int i = 0; i < 60 && preq !== 1'b1; i++) cyc(1);
        chk("pri_req", 3'h1, {2'h0, preq});
        chk("recovery", 3'h1, {2'h0, rec});
        cyc(1);
        chk("source", cfd_pkg::SRC_WDT, src);
        pen = 1'b0;
        pack = 1'b1;
        cyc(1);
        pack = 1'b0;
        pri_on = 1'b1;
        cyc(3);
        chk("pri_cleared", 3'h0, {1'b0, preq, rec});
        $display("t_pri done");
    endtask : t_pri
    // Watchdog selected, then watchdog oscillator off: no switch
    task t_block;
        for (int k = 0; k < 2; k++)
        begin
            sel = k ? cfd_pkg::SRC_IPO : cfd_pkg::SRC_WDT;
            wosc = k[0] ? 1'b0 : 1'b1;
            pen = 1'b1;
            pri_on = 1'b0;
            cyc(40);
            chk("no_switch", 3'h0, {2'h0, rec});
            chk("blk_req", 3'h1, {2'h0, preq});
            pen = 1'b0;
            pri_on = 1'b1;
            pack = 1'b1;
            cyc(1);
            pack = 1'b0;
            cyc(2);
        end
        wosc = 1'b1;
        $display("t_block done");
    endtask : t_block
    // Watchdog loss: timed event, no switch, primary blind
    task t_wdt;
        wen = 1'b1;
        cyc(2);
        wdt_on = 1'b0;
        cyc(WF - 6);
        chk("wdt_early", 3'h0, {2'h0, wreq});
        for (int i = 0; i < 12 && wreq !== 1'b1; i++) cyc(1);
        chk("wdt_req", 3'h1, {2'h0, wreq});
        chk("wdt_dead", 3'h1, {2'h0, dead});
        chk("wdt_src", cfd_pkg::SRC_IPO, src);
        // Revive the watchdog, let a primary event pend, then lose the watchdog again
        wen = 1'b0;
        wack = 1'b1;
        wdt_on = 1'b1;
        cyc(1);
        wack = 1'b0;
        cyc(4);
        chk("wdt_alive", 3'h0, {1'b0, wreq, dead});
        pen = 1'b1;
        pri_on = 1'b0;
        for (int i = 0; i < 60 && preq !== 1'b1; i++) cyc(1);
        wen = 1'b1;
        wdt_on = 1'b0;
        for (int i = 0; i < WF + 12 && wreq !== 1'b1; i++) cyc(1);
        chk("wdt_req2", 3'h3, {1'b0, wreq, preq});
        pack = 1'b1;
        cyc(1);
        pack = 1'b0;
        chk("pri_blind", 3'h0, {2'h0, preq});
        $display("t_wdt done");
    endtask : t_wdt
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // Main sequence and watchdog
    initial
    begin
        cyc(16);
        rst_n = 1'b1;
        cyc(4);
        chk("reset_flags", 3'h0, {preq, wreq, rec});
        chk("reset_dead", 3'h0, {2'h0, dead});
        chk("reset_src", cfd_pkg::SRC_RESET, src);
        t_pri();
        t_block();
        t_wdt();
        summarize();
    end
    initial
    begin
        cyc(3000);
        num_errors++;
        summarize();
    end
endmodule : clock_failure_detect_recovery_bench
